// >>> core/dtd_defines.svh
// constants for the data-transfer decoder: depths, opcode clock counts
`ifndef DTD_DEFINES_SVH
`define DTD_DEFINES_SVH
// ----------------------------------------
// queue
// ----------------------------------------
`define DTD_QDEPTH_16  3'h6
`define DTD_QDEPTH_8   3'h4
// ----------------------------------------
// minimum clocks, register / memory forms
// ----------------------------------------
`define DTD_MOV_RR     7'h02
`define DTD_MOV_RM     7'h0c
`define DTD_MOV_MR     7'h09
`define DTD_MOVI_B     7'h0c
`define DTD_MOVI_W     7'h0d
`define DTD_MOVIR_B    7'h03
`define DTD_MOVIR_W    7'h04
`define DTD_MOVA_LD    7'h08
`define DTD_MOVA_ST    7'h09
`define DTD_SEG_RR     7'h02
`define DTD_TOSEG_M16  7'h09
`define DTD_TOSEG_M8   7'h0d
`define DTD_FRSEG_M16  7'h0b
`define DTD_FRSEG_M8   7'h0f
`define DTD_PUSHM_16   7'h10
`define DTD_PUSHM_8    7'h14
`define DTD_PUSHR_16   7'h0a
`define DTD_PUSHR_8    7'h0e
`define DTD_PUSHS_16   7'h09
`define DTD_PUSHS_8    7'h0d
`define DTD_PUSHI_16   7'h0a
`define DTD_PUSHI_8    7'h0e
`define DTD_PUSHA_16   7'h24
`define DTD_PUSHA_8    7'h44
`define DTD_POPM_16    7'h14
`define DTD_POPM_8     7'h18
`define DTD_POPR_16    7'h0a
`define DTD_POPR_8     7'h0e
`define DTD_POPS_16    7'h08
`define DTD_POPS_8     7'h0c
`define DTD_POPA_16    7'h33
`define DTD_POPA_8     7'h53
`define DTD_XCHG_R     7'h04
`define DTD_XCHG_M     7'h11
`define DTD_XCHG_A     7'h03
`define DTD_IN_FIX     7'h0a
`define DTD_IN_VAR     7'h08
`define DTD_OUT_FIX    7'h09
`define DTD_OUT_VAR    7'h07
`define DTD_LOOKUP_16  7'h0b
`define DTD_LOOKUP_8   7'h0f
`define DTD_LEO        7'h06
`define DTD_LPTR_16    7'h12
`define DTD_LPTR_8     7'h1a
`define DTD_F2AH       7'h02
`define DTD_AH2F       7'h03
`define DTD_PUSHF_16   7'h09
`define DTD_PUSHF_8    7'h0d
`define DTD_POPF_16    7'h08
`define DTD_POPF_8     7'h0c
`define DTD_ILLEGAL    7'h01
`define DTD_MAX_EXTRA  2'h2
`endif

// >>> core/dtd_pkg.sv
// types shared by the data-transfer decoder
package dtd_pkg;
    typedef enum logic [1:0] {
        DTD_ST_FETCH = 2'h0,
        DTD_ST_EXEC  = 2'h1
    } dtd_state_t;

    typedef struct packed {
        logic [2:0] len;
        logic [6:0] clk;
        logic       mem;
        logic       ill;
    } dtd_dec_t;
endpackage : dtd_pkg

// >>> core/dtd_decoder.sv
// prefetch queue, data-transfer decoder with clock counts, halt/low-power bus pins
`include "dtd_defines.svh"

// Behaviour
// RQ1: halt T1 floats lines after read, else drives
// RQ2: halt holds other control lines inactive
// RQ3: idle or powerdown drives address lines zero
// RQ4: sixteen-bit variant has six-byte prefetch queue
// RQ5: eight-bit variant has four-byte queue, may stall
// RQ6: jump counts include fetch at destination
// RQ7: memory access adds one or two clocks
// RQ8: listed counts are minimums under ideal conditions
// RQ9: segment load from reg/mem, 2/9 or 2/13
// RQ10: segment store to reg/mem, 2/11 or 2/15
// RQ11: table lookup byte, 11 or 15 clocks
// RQ12: load effective offset, 6 clocks
// RQ13: far pointer with data segment, 18/26
// RQ14: far pointer with extra segment, 18/26
// RQ15: flags to high accumulator, 2 clocks
// RQ16: high accumulator to flags, 3 clocks
// RQ17: other moves, stack, exchange, port ops decoded
// RQ18: execution stalls until queue holds whole instruction
module dtd_decoder (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        variant_8bit,
    input  wire logic        fetch_valid,
    input  wire logic [7:0]  fetch_byte,
    input  wire logic        flush_queue,
    input  wire logic [1:0]  mem_extra,
    input  wire logic        halt_active,
    input  wire logic        halt_t1,
    input  wire logic        low_power,
    input  wire logic [15:0] bus_ad_out,
    input  wire logic        bus_ad_oe_n,
    input  wire logic [3:0]  bus_addr_hi,
    input  wire logic        bus_rd_n,
    input  wire logic        bus_wr_n,
    input  wire logic        bus_ale,
    output logic             fetch_ready,
    output logic             insn_valid,
    output logic [7:0]       insn_opcode,
    output logic [7:0]       insn_modrm,
    output logic [2:0]       insn_len,
    output logic [6:0]       insn_clocks,
    output logic             insn_illegal,
    output logic             exec_busy,
    output logic             exec_stall,
    output logic [15:0]      addr_data_lines,
    output logic             addr_data_oe_n,
    output logic [3:0]       addr_hi_lines,
    output logic             rd_n,
    output logic             wr_n,
    output logic             ale
);
    // ----------------------------------------
    // decode table
    // ----------------------------------------
    function automatic dtd_pkg::dtd_dec_t decode(
        input logic [7:0] b0,
        input logic [7:0] b1,
        input logic       have2,
        input logic       v8
    );
        dtd_pkg::dtd_dec_t d;
        logic              rr;
        logic [2:0]        disp;
        logic              mrm;
        d    = '0;
        rr   = (b1[7:6] == 2'h3);
        mrm  = 1'b0;
        disp = (b1[7:6] == 2'h1) ? 3'h1 : 3'h0;
        if (b1[7:6] == 2'h2 || (b1[7:6] == 2'h0 && b1[2:0] == 3'h6)) begin
            disp = 3'h2;
        end
        d.len = 3'h1;
        casez (b0)
            8'b1000_100?: {mrm, d.clk} = {1'b1, rr ? `DTD_MOV_RR : `DTD_MOV_RM};
            8'b1000_101?: {mrm, d.clk} = {1'b1, rr ? `DTD_MOV_RR : `DTD_MOV_MR};
            8'b1100_011?: begin
                mrm            = 1'b1;
                {d.len, d.clk} = b0[0] ? {3'h3, `DTD_MOVI_W} : {3'h2, `DTD_MOVI_B};
            end
            8'b1011_????: {d.len, d.clk} = b0[3] ? {3'h3, `DTD_MOVIR_W} : {3'h2, `DTD_MOVIR_B};
            8'b1010_00??: {d.len, d.mem, d.clk} = {3'h3, 1'b1, b0[1] ? `DTD_MOVA_ST : `DTD_MOVA_LD};
            8'b1000_1110: begin
                {mrm, d.ill} = {1'b1, b1[5]};
                d.clk        = rr ? `DTD_SEG_RR : (v8 ? `DTD_TOSEG_M8 : `DTD_TOSEG_M16); // [RQ9]
            end
            8'b1000_1100: begin
                {mrm, d.ill} = {1'b1, b1[5]};
                d.clk        = rr ? `DTD_SEG_RR : (v8 ? `DTD_FRSEG_M8 : `DTD_FRSEG_M16); // [RQ10]
            end
            8'b1111_1111: begin
                {mrm, d.ill, d.mem} = {1'b1, b1[5:3] != 3'h6, 1'b1};
                d.clk               = v8 ? `DTD_PUSHM_8 : `DTD_PUSHM_16; // [RQ17]
            end
            8'b1000_1111: begin
                {mrm, d.ill, d.mem} = {1'b1, b1[5:3] != 3'h0, 1'b1};
                d.clk               = v8 ? `DTD_POPM_8 : `DTD_POPM_16;
            end
            8'b0101_0???: {d.mem, d.clk} = {1'b1, v8 ? `DTD_PUSHR_8 : `DTD_PUSHR_16};
            8'b0101_1???: {d.mem, d.clk} = {1'b1, v8 ? `DTD_POPR_8 : `DTD_POPR_16};
            8'b000?_?110: {d.mem, d.clk} = {1'b1, v8 ? `DTD_PUSHS_8 : `DTD_PUSHS_16};
            8'b000?_?111: begin
                // popping the code segment is not a valid encoding
                {d.ill, d.mem} = {b0[4:3] == 2'h1, 1'b1};
                d.clk          = v8 ? `DTD_POPS_8 : `DTD_POPS_16;
            end
            8'b0110_10?0: begin
                {d.len, d.mem} = {b0[1] ? 3'h2 : 3'h3, 1'b1};
                d.clk          = v8 ? `DTD_PUSHI_8 : `DTD_PUSHI_16;
            end
            8'b0110_0000: {d.mem, d.clk} = {1'b1, v8 ? `DTD_PUSHA_8 : `DTD_PUSHA_16};
            8'b0110_0001: {d.mem, d.clk} = {1'b1, v8 ? `DTD_POPA_8 : `DTD_POPA_16};
            8'b1000_011?: {mrm, d.clk} = {1'b1, rr ? `DTD_XCHG_R : `DTD_XCHG_M};
            8'b1001_0???: d.clk = `DTD_XCHG_A;
            8'b1110_010?: {d.len, d.clk} = {3'h2, `DTD_IN_FIX};
            8'b1110_110?: d.clk = `DTD_IN_VAR;
            8'b1110_011?: {d.len, d.clk} = {3'h2, `DTD_OUT_FIX};
            8'b1110_111?: d.clk = `DTD_OUT_VAR;
            8'b1101_0111: {d.mem, d.clk} = {1'b1, v8 ? `DTD_LOOKUP_8 : `DTD_LOOKUP_16}; // [RQ11]
            8'b1000_1101: {mrm, d.clk} = {1'b1, `DTD_LEO}; // [RQ12]
            8'b1100_010?: begin
                {mrm, d.ill} = {1'b1, rr}; // [RQ13] [RQ14]
                d.clk        = v8 ? `DTD_LPTR_8 : `DTD_LPTR_16; // [RQ13] [RQ14]
            end
            8'b1001_1111: d.clk = `DTD_F2AH; // [RQ15]
            8'b1001_1110: d.clk = `DTD_AH2F; // [RQ16]
            8'b1001_1100: {d.mem, d.clk} = {1'b1, v8 ? `DTD_PUSHF_8 : `DTD_PUSHF_16};
            8'b1001_1101: {d.mem, d.clk} = {1'b1, v8 ? `DTD_POPF_8 : `DTD_POPF_16};
            default: d.ill = 1'b1;
        endcase
        if (mrm) begin
            // until the modrm byte is queued only two bytes are needed, and a stale one proves nothing
            d.len = have2 ? d.len + 3'h1 + (rr ? 3'h0 : disp) : 3'h2;
            d.mem = d.mem | !rr;
            d.ill = d.ill && have2;
        end
        if (d.ill) begin
            {d.len, d.mem, d.clk} = {3'h1, 1'b0, `DTD_ILLEGAL};
        end
        return d;
    endfunction : decode

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0]          q_reg [6];
    logic [7:0]          q_next [6];
    logic [2:0]          cnt_reg, cnt_next;
    logic                v8_reg, v8_next;
    dtd_pkg::dtd_state_t st_reg, st_next;
    logic [6:0]          left_reg, left_next;
    logic                fr_reg, fr_next;
    logic                iv_reg, iv_next;
    logic [7:0]          op_reg, op_next;
    logic [7:0]          mrm_reg, mrm_next;
    logic [2:0]          len_reg, len_next;
    logic [6:0]          clk_reg, clk_next;
    logic                ill_reg, ill_next;
    logic                busy_reg, busy_next;
    logic                stall_reg, stall_next;
    dtd_pkg::dtd_dec_t   dec;
    logic                take;
    logic [2:0]          pop;
    logic [1:0]          extra;

    // ----------------------------------------
    // queue and execution sequencing
    // ----------------------------------------
    always_comb begin
        v8_next    = v8_reg;
        dec        = decode(q_reg[0], q_reg[1], cnt_reg >= 3'h2, v8_reg);
        take       = (st_reg == dtd_pkg::DTD_ST_FETCH) && !flush_queue && (cnt_reg >= dec.len); // [RQ18]
        pop        = take ? dec.len : 3'h0;
        extra      = (mem_extra > `DTD_MAX_EXTRA) ? `DTD_MAX_EXTRA : mem_extra;
        st_next    = st_reg;
        left_next  = left_reg;
        iv_next    = 1'b0;
        op_next    = op_reg;
        mrm_next   = mrm_reg;
        len_next   = len_reg;
        clk_next   = clk_reg;
        ill_next   = ill_reg;
        stall_next = (st_reg == dtd_pkg::DTD_ST_FETCH) && !take; // [RQ5] [RQ18]
        for (int i = 0; i < 6; i++) begin
            q_next[i] = (i + int'(pop) < 6) ? q_reg[i + int'(pop)] : q_reg[i];
        end
        cnt_next = cnt_reg - pop;
        if (flush_queue) begin
            // a taken jump restarts fetching; its destination fetch is in its own count
            cnt_next = 3'h0; // [RQ6]
        end else if (fetch_valid && fr_reg) begin
            q_next[cnt_next] = fetch_byte; // [RQ4] [RQ5]
            cnt_next         = cnt_next + 3'h1;
        end
        fr_next = cnt_next < (v8_reg ? `DTD_QDEPTH_8 : `DTD_QDEPTH_16); // [RQ4] [RQ5]
        case (st_reg)
            dtd_pkg::DTD_ST_FETCH: begin
                if (take) begin
                    iv_next  = 1'b1;
                    op_next  = q_reg[0];
                    mrm_next = q_reg[1];
                    len_next = dec.len;
                    ill_next = dec.ill;
                    // minimum plus handshake slip on memory forms
                    clk_next = dec.clk + (dec.mem ? {5'h00, extra} : 7'h00); // [RQ7] [RQ8]
                    if (clk_next > 7'h01) begin
                        left_next = clk_next - 7'h01;
                        st_next   = dtd_pkg::DTD_ST_EXEC;
                    end
                end
            end
            dtd_pkg::DTD_ST_EXEC: begin
                left_next = left_reg - 7'h01;
                if (left_reg == 7'h01) begin
                    st_next = dtd_pkg::DTD_ST_FETCH;
                end
            end
            default: st_next = dtd_pkg::DTD_ST_FETCH;
        endcase
        busy_next = (st_next == dtd_pkg::DTD_ST_EXEC);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_reg     <= '{default: 8'h00};
            cnt_reg   <= 3'h0;
            v8_reg    <= variant_8bit;
            st_reg    <= dtd_pkg::DTD_ST_FETCH;
            left_reg  <= 7'h00;
            fr_reg    <= 1'b0;
            iv_reg    <= 1'b0;
            op_reg    <= 8'h00;
            mrm_reg   <= 8'h00;
            len_reg   <= 3'h0;
            clk_reg   <= 7'h00;
            ill_reg   <= 1'b0;
            busy_reg  <= 1'b0;
            stall_reg <= 1'b0;
        end else begin
            q_reg     <= q_next;
            cnt_reg   <= cnt_next;
            v8_reg    <= v8_next;
            st_reg    <= st_next;
            left_reg  <= left_next;
            fr_reg    <= fr_next;
            iv_reg    <= iv_next;
            op_reg    <= op_next;
            mrm_reg   <= mrm_next;
            len_reg   <= len_next;
            clk_reg   <= clk_next;
            ill_reg   <= ill_next;
            busy_reg  <= busy_next;
            stall_reg <= stall_next;
        end
    end

    // ----------------------------------------
    // bus pins in halt and low-power
    // ----------------------------------------
    logic [15:0] ad_reg, ad_next;
    logic        oe_n_reg, oe_n_next;
    logic [3:0]  ahi_reg, ahi_next;
    logic        rd_n_reg, rd_n_next;
    logic        wr_n_reg, wr_n_next;
    logic        ale_reg, ale_next;
    logic        prd_reg, prd_next;

    always_comb begin
        prd_next  = prd_reg;
        if (!bus_rd_n) begin
            prd_next = 1'b1;
        end else if (!bus_wr_n) begin
            prd_next = 1'b0;
        end
        ad_next   = bus_ad_out;
        oe_n_next = bus_ad_oe_n;
        ahi_next  = bus_addr_hi;
        rd_n_next = bus_rd_n;
        wr_n_next = bus_wr_n;
        ale_next  = bus_ale;
        if (low_power) begin
            ad_next   = 16'h0000; // [RQ3]
            oe_n_next = 1'b0; // [RQ3]
            ahi_next  = 4'h0; // [RQ3]
            {rd_n_next, wr_n_next, ale_next} = 3'h6;
        end else if (halt_active) begin
            // contents are meaningless; holding the old value saves toggling
            ad_next   = ad_reg; // [RQ1]
            oe_n_next = halt_t1 && prd_reg; // [RQ1]
            rd_n_next = 1'b1; // [RQ2]
            wr_n_next = 1'b1; // [RQ2]
            ale_next  = 1'b0; // [RQ2]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ad_reg   <= 16'h0000;
            oe_n_reg <= 1'b1;
            ahi_reg  <= 4'h0;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            ale_reg  <= 1'b0;
            prd_reg  <= 1'b0;
        end else begin
            ad_reg   <= ad_next;
            oe_n_reg <= oe_n_next;
            ahi_reg  <= ahi_next;
            rd_n_reg <= rd_n_next;
            wr_n_reg <= wr_n_next;
            ale_reg  <= ale_next;
            prd_reg  <= prd_next;
        end
    end

    assign fetch_ready     = fr_reg;
    assign insn_valid      = iv_reg;
    assign insn_opcode     = op_reg;
    assign insn_modrm      = mrm_reg;
    assign insn_len        = len_reg;
    assign insn_clocks     = clk_reg;
    assign insn_illegal    = ill_reg;
    assign exec_busy       = busy_reg;
    assign exec_stall      = stall_reg;
    assign addr_data_lines = ad_reg;
    assign addr_data_oe_n  = oe_n_reg;
    assign addr_hi_lines   = ahi_reg;
    assign rd_n            = rd_n_reg;
    assign wr_n            = wr_n_reg;
    assign ale             = ale_reg;
endmodule : dtd_decoder

// >>> sim/dtd_decoder_checker.sv
// assertions on the decoder pins
module dtd_decoder_checker (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        halt_active,
    input wire logic        halt_t1,
    input wire logic        low_power,
    input wire logic        bus_rd_n,
    input wire logic        bus_wr_n,
    input wire logic        insn_valid,
    input wire logic [7:0]  insn_opcode,
    input wire logic [2:0]  insn_len,
    input wire logic [6:0]  insn_clocks,
    input wire logic        insn_illegal,
    input wire logic        exec_busy,
    input wire logic        exec_stall,
    input wire logic [15:0] addr_data_lines,
    input wire logic        addr_data_oe_n,
    input wire logic [3:0]  addr_hi_lines,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic        ale
);
    // ----
    // last bus access kind
    // ----
    logic last_rd_reg;
    logic last_rd_next;
    always_comb begin
        last_rd_next = last_rd_reg;
        if (!bus_rd_n)
            last_rd_next = 1'b1;
        else if (!bus_wr_n)
            last_rd_next = 1'b0;
    end
    always_ff @(posedge sys_clk) begin
        last_rd_reg <= rst ? 1'b0 : last_rd_next;
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_halt_t1;
        halt_active && halt_t1 && !low_power && !$past(rst);
    endsequence
    sequence s_quiet2;
        !insn_valid [*2];
    endsequence
    property p_halt_float;
        s_halt_t1 ##0 last_rd_reg |=> addr_data_oe_n;
    endproperty
    property p_halt_drive;
        s_halt_t1 ##0 (!last_rd_reg && $past(halt_active)) |=> !addr_data_oe_n && $stable(addr_data_lines);
    endproperty
    property p_halt_ctrl;
        halt_active && !low_power |=> rd_n && wr_n && !ale;
    endproperty
    property p_low_pow;
        low_power && !$past(rst) |=> addr_data_lines == 16'h0000 && addr_hi_lines == 4'h0 && !addr_data_oe_n;
    endproperty
    property p_illegal;
        insn_valid && insn_illegal |-> insn_len == 3'h1 && insn_clocks == 7'h01;
    endproperty
    property p_f2ah;
        insn_valid && insn_opcode == 8'h9f |-> insn_clocks == 7'h02 && insn_len == 3'h1;
    endproperty
    property p_ah2f;
        insn_valid && insn_opcode == 8'h9e |-> insn_clocks == 7'h03 ##1 s_quiet2;
    endproperty
    property p_busy;
        insn_valid && insn_clocks == 7'h02 |-> exec_busy ##1 !exec_busy;
    endproperty
    property p_stall;
        exec_stall |-> !insn_valid;
    endproperty
    a_halt_float: assert property (p_halt_float) else $error("address lines driven in halt after read");
    a_halt_drive: assert property (p_halt_drive) else $error("address lines not held in halt after write");
    a_halt_ctrl: assert property (p_halt_ctrl) else $error("control line active in halt");
    a_low_pow: assert property (p_low_pow) else $error("address lines not zero in low power");
    a_illegal: assert property (p_illegal) else $error("illegal opcode length or clocks wrong");
    a_f2ah: assert property (p_f2ah) else $error("flags to high byte count wrong");
    a_ah2f: assert property (p_ah2f) else $error("high byte to flags count or spacing wrong");
    a_busy: assert property (p_busy) else $error("busy length wrong for two clock insn");
    a_stall: assert property (p_stall) else $error("stall together with decode");
endmodule : dtd_decoder_checker

// >>> sim/dtd_prog_mem.sv
// program memory model feeding the prefetch queue
module dtd_prog_mem (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       fetch_ready,
    input  wire logic       flush_queue,
    input  wire logic       slow,
    output logic            fetch_valid,
    output logic [7:0]      fetch_byte,
    output int              pops
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] q[$];
    logic       phase;
    task automatic put(input logic [7:0] b);
        q.push_back(b);
    endtask : put
    task automatic clear();
        q.delete();
    endtask : clear
    initial begin
        fetch_valid = 1'b0;
        fetch_byte = 8'h00;
        pops = 0;
        phase = 1'b0;
    end
    // byte held until taken; idle line toggles so stale data never looks valid
    always @(posedge sys_clk) begin
        if (!rst && fetch_valid && fetch_ready && !flush_queue) begin
            void'(q.pop_front());
            pops = pops + 1;
        end
        #1;
        phase = ~phase;
        fetch_valid = q.size() > 0 && (!slow || phase);
        fetch_byte = fetch_valid ? q[0] : ~fetch_byte;
    end
endmodule : dtd_prog_mem

// >>> sim/tb_dtd_decoder.sv
// self-checking bench for the data-transfer decoder
module tb_dtd_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    logic             sys_clk, rst, v8, flush, slow, halt, t1, lp, ad_oe_n, brd_n, bwr_n, bale;
    logic [1:0]       extra;
    logic [15:0]      ad_out;
    logic [3:0]       ahi;
    wire logic        fv, rdy, iv, ill, busy, stall, oe_n, rd_n, wr_n, ale;
    wire logic [7:0]  fb, opc, mrm;
    wire logic [2:0]  len;
    wire logic [6:0]  clks;
    wire logic [15:0] adl;
    wire logic [3:0]  ahl;
    int               pops, base, k, errors, comparisons;
    dtd_decoder DUT (.sys_clk(sys_clk), .rst(rst), .variant_8bit(v8), .fetch_valid(fv), .fetch_byte(fb),
        .flush_queue(flush), .mem_extra(extra), .halt_active(halt), .halt_t1(t1), .low_power(lp),
        .bus_ad_out(ad_out), .bus_ad_oe_n(ad_oe_n), .bus_addr_hi(ahi), .bus_rd_n(brd_n), .bus_wr_n(bwr_n),
        .bus_ale(bale), .fetch_ready(rdy), .insn_valid(iv), .insn_opcode(opc), .insn_modrm(mrm), .insn_len(len),
        .insn_clocks(clks), .insn_illegal(ill), .exec_busy(busy), .exec_stall(stall), .addr_data_lines(adl),
        .addr_data_oe_n(oe_n), .addr_hi_lines(ahl), .rd_n(rd_n), .wr_n(wr_n), .ale(ale));
    dtd_prog_mem mem (.sys_clk(sys_clk), .rst(rst), .fetch_ready(rdy), .flush_queue(flush), .slow(slow),
        .fetch_valid(fv), .fetch_byte(fb), .pops(pops));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ----
    // shared tasks
    // ----
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic wait_iv();
        k = 0;
        while (iv !== 1'b1) begin
            tick(1);
            k++;
            if (k > 300) begin
                chk("insn_valid", 16'h0001, {15'h0000, iv});
                test_done();
            end
        end
    endtask : wait_iv
    task automatic do_reset(input logic w);
        v8 = w;
        rst = 1'b1;
        tick(3);
        chk("fetch_ready", 16'h0000, {15'h0000, rdy});
        chk("addr_data_oe_n", 16'h0001, {15'h0000, oe_n});
        rst = 1'b0;
        tick(1);
    endtask : do_reset
    // queue the bytes, wait for the decode and judge it
    task automatic insn(input logic [31:0] b, input int n, input logic [2:0] l,
                        input logic [6:0] c16, input logic [6:0] c8, input logic il);
        for (int i = 0; i < n; i++)
            mem.put(b[31-8*i -: 8]);
        wait_iv();
        chk("insn_len", {13'h0000, l}, {13'h0000, len});
        chk("insn_clocks", {9'h000, v8 ? c8 : c16}, {9'h000, clks});
        chk("insn_illegal", {15'h0000, il}, {15'h0000, ill});
        tick(1);
    endtask : insn
    // ----
    // scenarios
    // ----
    task automatic t_table(input logic w);
        do_reset(w);
        insn(32'h9f00_0000, 1, 3'h1, 7'h02, 7'h02, 1'b0);
        insn(32'h9e00_0000, 1, 3'h1, 7'h03, 7'h03, 1'b0);
        insn(32'hd700_0000, 1, 3'h1, 7'h0b, 7'h0f, 1'b0);
        insn(32'h8dc0_0000, 2, 3'h2, 7'h06, 7'h06, 1'b0);
        insn(32'h8d46_0500, 3, 3'h3, 7'h06, 7'h06, 1'b0);
        insn(32'h8ed8_0000, 2, 3'h2, 7'h02, 7'h02, 1'b0);
        insn(32'h8e06_3412, 4, 3'h4, 7'h09, 7'h0d, 1'b0);
        insn(32'h8cd8_0000, 2, 3'h2, 7'h02, 7'h02, 1'b0);
        insn(32'h8c46_0500, 3, 3'h3, 7'h0b, 7'h0f, 1'b0);
        insn(32'hc506_0010, 4, 3'h4, 7'h12, 7'h1a, 1'b0);
        insn(32'hc487_0010, 4, 3'h4, 7'h12, 7'h1a, 1'b0);
        insn(32'hc4c0_0000, 2, 3'h1, 7'h01, 7'h01, 1'b1);
        insn(32'h0000_0000, 0, 3'h1, 7'h01, 7'h01, 1'b1);
        insn(32'h8806_0010, 4, 3'h4, 7'h0c, 7'h0c, 1'b0);
        insn(32'ha000_1000, 3, 3'h3, 7'h08, 7'h08, 1'b0);
        insn(32'h5000_0000, 1, 3'h1, 7'h0a, 7'h0e, 1'b0);
        insn(32'h6100_0000, 1, 3'h1, 7'h33, 7'h53, 1'b0);
        insn(32'he412_0000, 2, 3'h2, 7'h0a, 7'h0a, 1'b0);
        insn(32'hb812_3400, 3, 3'h3, 7'h04, 7'h04, 1'b0);
        insn(32'h9c00_0000, 1, 3'h1, 7'h09, 7'h0d, 1'b0);
        $display("decode table done, narrow bus %b", w);
    endtask : t_table
    task automatic t_extra();
        extra = 2'h1;
        insn(32'hd700_0000, 1, 3'h1, 7'h0c, 7'h10, 1'b0);
        extra = 2'h3;
        insn(32'hd700_0000, 1, 3'h1, 7'h0d, 7'h11, 1'b0);
        insn(32'he412_0000, 2, 3'h2, 7'h0a, 7'h0a, 1'b0);
        insn(32'h9f00_0000, 1, 3'h1, 7'h02, 7'h02, 1'b0);
        extra = 2'h0;
        $display("handshake slip done");
    endtask : t_extra
    task automatic t_depth(input logic w);
        base = pops;
        insn(32'hc506_0010, 4, 3'h4, 7'h12, 7'h1a, 1'b0);
        for (int i = 0; i < 8; i++)
            mem.put(8'h9f);
        tick(10);
        chk("queue_bytes", w ? 16'h0008 : 16'h000a, 16'(pops - base));
        chk("fetch_ready", 16'h0000, {15'h0000, rdy});
        tick(10);
        flush = 1'b1;
        mem.clear();
        tick(3);
        flush = 1'b0;
        tick(3);
        chk("fetch_ready", 16'h0001, {15'h0000, rdy});
        $display("queue depth done");
    endtask : t_depth
    task automatic t_stall();
        mem.put(8'h8e);
        tick(4);
        chk("exec_stall", 16'h0001, {15'h0000, stall});
        chk("insn_valid", 16'h0000, {15'h0000, iv});
        slow = 1'b1;
        insn(32'h0634_1200, 3, 3'h4, 7'h09, 7'h0d, 1'b0);
        slow = 1'b0;
        $display("stall done");
    endtask : t_stall
    task automatic t_space();
        mem.put(8'h9f);
        mem.put(8'h9f);
        mem.put(8'h9e);
        wait_iv();
        tick(1);
        k = 1;
        while (iv !== 1'b1 && k < 9) begin
            tick(1);
            k++;
        end
        chk("insn_spacing", 16'h0002, 16'(k));
        tick(1);
        insn(32'h0000_0000, 0, 3'h1, 7'h03, 7'h03, 1'b0);
        $display("back to back done");
    endtask : t_space
    task automatic t_bus();
        ad_out = 16'h1234;
        ahi = 4'h5;
        ad_oe_n = 1'b0;
        brd_n = 1'b0;
        bale = 1'b1;
        tick(2);
        chk("addr_data_lines", 16'h1234, adl);
        brd_n = 1'b1;
        halt = 1'b1;
        t1 = 1'b1;
        tick(2);
        chk("addr_data_oe_n", 16'h0001, {15'h0000, oe_n});
        chk("rd_wr_ale", 16'h0006, {13'h0000, rd_n, wr_n, ale});
        halt = 1'b0;
        bwr_n = 1'b0;
        ad_out = 16'ha5a5;
        tick(1);
        bwr_n = 1'b1;
        halt = 1'b1;
        ad_out = 16'h0f0f;
        tick(2);
        chk("addr_data_oe_n", 16'h0000, {15'h0000, oe_n});
        chk("addr_data_lines", 16'ha5a5, adl);
        chk("rd_wr_ale", 16'h0006, {13'h0000, rd_n, wr_n, ale});
        lp = 1'b1;
        halt = 1'b0;
        tick(2);
        chk("addr_data_lines", 16'h0000, adl);
        chk("addr_hi_lines", 16'h0000, {12'h000, ahl});
        lp = 1'b0;
        $display("bus pins done");
    endtask : t_bus
    initial begin
        {rst, v8, flush, slow, halt, t1, lp, brd_n, bwr_n, bale, ad_oe_n} = 11'h40d;
        extra = 2'h0;
        ad_out = 16'h0000;
        ahi = 4'h0;
        errors = 0;
        comparisons = 0;
        tick(1);
        for (int w = 0; w < 2; w++) begin
            t_table(w[0]);
            t_extra();
            t_depth(w[0]);
            t_stall();
            t_space();
        end
        t_bus();
        test_done();
    end
endmodule : tb_dtd_decoder

bind dtd_decoder dtd_decoder_checker u_chk (.*);
